// [rtl/ivp_pkg.sv]
// shared constants and carrier types for the vectored interrupt prioritizer
package ivp_pkg;
    // ------------------------------------------------------------
    // table geometry
    // ------------------------------------------------------------
    localparam int NUM_TRAP = 8;
    localparam int NUM_IRQ = 118;
    localparam int NUM_VEC = 126;
    localparam int VEC_W = 7;
    localparam int LVL_W = 4;
    localparam int PRI_W = 3;
    localparam int ADDR_W = 24;
    localparam logic [23:0] PRIMARY_TABLE_BASE = 24'h000004;
    localparam logic [23:0] ALT_TABLE_BASE = 24'h000104;
    localparam logic [23:0] RESET_FETCH_ADDR = 24'h000000;
    localparam logic [3:0] TRAP_LEVEL = 4'h8;
    // ------------------------------------------------------------
    // register map (byte offsets)
    // ------------------------------------------------------------
    localparam int PADDR_W = 12;
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_TRAP = 12'h008;
    localparam logic [11:0] OFS_FLAG = 12'h010;
    localparam logic [11:0] OFS_ENABLE = 12'h020;
    localparam logic [11:0] OFS_PRIORITY = 12'h040;
    localparam int FLAG_WORDS = 4;
    localparam int PRI_WORDS = 15;
    localparam int PRI_PER_WORD = 8;
    localparam int PRI_NIB = 4;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_ALT_BIT = 15;
    localparam int CTRL_IPL_LSB = 5;
    localparam int CTRL_TOP_BIT = 8;
    localparam int STAT_LVL_LSB = 8;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } ivp_apb_req_t;
    typedef struct packed {
        logic req;
        logic [6:0] vec_num;
        logic [23:0] vec_addr;
        logic [3:0] level;
    } ivp_core_req_t;
endpackage : ivp_pkg

// [rtl/ivp_source_cell.sv]
// one interrupt source: sticky request flag, enable and priority field
`timescale 1ns/1ps
module ivp_source_cell (
    input wire logic clk,
    input wire logic rst,
    input wire logic irq_in,
    input wire logic flag_we,
    input wire logic flag_wval,
    input wire logic en_we,
    input wire logic en_wval,
    input wire logic pri_we,
    input wire logic [2:0] pri_wval,
    output logic flag_r,
    output logic en_r,
    output logic [2:0] pri_r
);
    // hardware set beats a software write of zero in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= irq_in | (flag_we ? flag_wval : flag_r);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            en_r <= 1'b0;
        end else if (en_we) begin
            en_r <= en_wval;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pri_r <= 3'h0;
        end else if (pri_we) begin
            pri_r <= pri_wval;
        end
    end
endmodule : ivp_source_cell

// [rtl/ivp_winner_select.sv]
// combinational search for the highest-level pending vector
`timescale 1ns/1ps
module ivp_winner_select (
    input wire logic [ivp_pkg::NUM_VEC-1:0] eligible,
    input wire logic [ivp_pkg::NUM_VEC*ivp_pkg::LVL_W-1:0] levels,
    output logic found,
    output logic [ivp_pkg::VEC_W-1:0] win_vec,
    output logic [ivp_pkg::LVL_W-1:0] win_lvl
);
    import ivp_pkg::*;

    // strict compare while scanning upward: equal levels keep the lower vector
    always_comb begin
        found = 1'b0;
        win_vec = '0;
        win_lvl = '0;
        for (int i = 0; i < NUM_VEC; i++) begin
            if (eligible[i] && levels[i*LVL_W +: LVL_W] > win_lvl) begin
                found = 1'b1;
                win_vec = VEC_W'(i);
                win_lvl = levels[i*LVL_W +: LVL_W];
            end
        end
    end
endmodule : ivp_winner_select

// [rtl/ivp_controller.sv]
// vectored interrupt prioritizer with apb register access
`timescale 1ns/1ps
module ivp_controller (
    input wire logic clk,
    input wire logic rst,
    input wire ivp_pkg::ivp_apb_req_t apb_req,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [ivp_pkg::NUM_IRQ-1:0] irq_in,
    input wire logic [ivp_pkg::NUM_TRAP-1:0] trap_in,
    input wire logic cpu_priority_top_bit,
    output ivp_pkg::ivp_core_req_t core_req
);
    import ivp_pkg::*;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic setup_phase;
    logic wr_commit;
    logic hit_ctrl;
    logic hit_status;
    logic hit_trap;
    logic hit_flag;
    logic hit_enable;
    logic hit_pri;
    logic [11:0] flag_rel;
    logic [11:0] en_rel;
    logic [11:0] pri_rel;
    logic [1:0] flag_idx;
    logic [1:0] en_idx;
    logic [3:0] pri_idx;

    assign setup_phase = apb_req.psel & ~apb_req.penable;
    assign wr_commit = apb_req.psel & apb_req.penable & pready & apb_req.pwrite;
    assign flag_rel = apb_req.paddr - OFS_FLAG;
    assign en_rel = apb_req.paddr - OFS_ENABLE;
    assign pri_rel = apb_req.paddr - OFS_PRIORITY;
    assign flag_idx = flag_rel[3:2];
    assign en_idx = en_rel[3:2];
    assign pri_idx = pri_rel[5:2];
    assign hit_ctrl = apb_req.paddr == OFS_CTRL;
    assign hit_status = apb_req.paddr == OFS_STATUS;
    assign hit_trap = apb_req.paddr == OFS_TRAP;
    assign hit_flag = apb_req.paddr >= OFS_FLAG && apb_req.paddr < OFS_ENABLE && apb_req.paddr[1:0] == 2'h0;
    assign hit_enable = apb_req.paddr >= OFS_ENABLE && en_rel < 12'(FLAG_WORDS * 4) && apb_req.paddr[1:0] == 2'h0;
    assign hit_pri = apb_req.paddr >= OFS_PRIORITY && pri_rel < 12'(PRI_WORDS * 4) && apb_req.paddr[1:0] == 2'h0;

    // ------------------------------------------------------------
    // control and trap state
    // ------------------------------------------------------------
    logic alt_table_select_r;
    logic [2:0] cpu_priority_level_r;
    logic [NUM_TRAP-1:0] trap_flag_r;
    logic [VEC_W-1:0] pending_vector_number_r;
    logic [LVL_W-1:0] pending_priority_level_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            alt_table_select_r <= 1'b0;
            cpu_priority_level_r <= 3'h0;
        end else if (wr_commit && hit_ctrl) begin
            alt_table_select_r <= apb_req.pwdata[CTRL_ALT_BIT];
            cpu_priority_level_r <= apb_req.pwdata[CTRL_IPL_LSB +: 3];
        end
    end

    // traps ignore the enables and are masked only by the core's top level bit; write one to clear, a new trap wins over it
    always_ff @(posedge clk) begin
        if (rst) begin
            trap_flag_r <= '0;
        end else if (wr_commit && hit_trap) begin
            trap_flag_r <= trap_in | (trap_flag_r & ~apb_req.pwdata[NUM_TRAP-1:0]);
        end else begin
            trap_flag_r <= trap_in | trap_flag_r;
        end
    end

    // ------------------------------------------------------------
    // per-source cells
    // ------------------------------------------------------------
    logic [NUM_IRQ-1:0] flag;
    logic [NUM_IRQ-1:0] enable;
    logic [32*FLAG_WORDS-1:0] flag_pad;
    logic [32*FLAG_WORDS-1:0] enable_pad;
    logic [32*PRI_WORDS-1:0] pri_flat;
    logic [NUM_VEC-1:0] eligible;
    logic [NUM_VEC*LVL_W-1:0] levels;

    assign flag_pad = {{(32 * FLAG_WORDS - NUM_IRQ){1'b0}}, flag};
    assign enable_pad = {{(32 * FLAG_WORDS - NUM_IRQ){1'b0}}, enable};

    genvar t;
    generate
        for (t = 0; t < NUM_TRAP; t++) begin : g_trap
            assign eligible[t] = trap_flag_r[t];
            assign levels[t*LVL_W +: LVL_W] = TRAP_LEVEL;
        end
    endgenerate

    genvar s;
    generate
        for (s = 0; s < NUM_IRQ; s++) begin : g_src
            localparam int W = s / 32;
            localparam int B = s % 32;
            localparam int PW = s / PRI_PER_WORD;
            localparam int PB = (s % PRI_PER_WORD) * PRI_NIB;
            logic [2:0] pri;
            ivp_source_cell u_cell (
                .clk(clk),
                .rst(rst),
                .irq_in(irq_in[s]),
                .flag_we(wr_commit && hit_flag && flag_idx == 2'(W)),
                .flag_wval(apb_req.pwdata[B]),
                .en_we(wr_commit && hit_enable && en_idx == 2'(W)),
                .en_wval(apb_req.pwdata[B]),
                .pri_we(wr_commit && hit_pri && pri_idx == 4'(PW)),
                .pri_wval(apb_req.pwdata[PB +: PRI_W]),
                .flag_r(flag[s]),
                .en_r(enable[s]),
                .pri_r(pri)
            );
            assign pri_flat[s*PRI_NIB +: PRI_NIB] = {1'b0, pri};
            // request number s sits at vector s + 8
            assign eligible[NUM_TRAP + s] = flag[s] & enable[s];
            assign levels[(NUM_TRAP + s)*LVL_W +: LVL_W] = {1'b0, pri};
        end
        for (s = NUM_IRQ * PRI_NIB; s < 32 * PRI_WORDS; s++) begin : g_pad
            assign pri_flat[s] = 1'b0;
        end
    endgenerate

    // ------------------------------------------------------------
    // arbitration and core request
    // ------------------------------------------------------------
    logic found;
    logic [VEC_W-1:0] win_vec;
    logic [LVL_W-1:0] win_lvl;
    logic [LVL_W-1:0] cpu_level;
    logic [23:0] table_base;
    logic [23:0] win_addr;

    ivp_winner_select u_sel (
        .eligible(eligible),
        .levels(levels),
        .found(found),
        .win_vec(win_vec),
        .win_lvl(win_lvl)
    );

    assign cpu_level = {cpu_priority_top_bit, cpu_priority_level_r};
    assign table_base = alt_table_select_r ? ALT_TABLE_BASE : PRIMARY_TABLE_BASE;
    // two bytes of program address per vector slot
    assign win_addr = table_base + {16'h0000, win_vec, 1'b0};

    // single registered stage: constant latency from flag to request
    always_ff @(posedge clk) begin
        if (rst) begin
            core_req <= '0;
        end else begin
            core_req.req <= found && win_lvl > cpu_level;
            core_req.vec_num <= win_vec;
            core_req.vec_addr <= win_addr;
            core_req.level <= win_lvl;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pending_vector_number_r <= '0;
            pending_priority_level_r <= '0;
        end else begin
            pending_vector_number_r <= found ? win_vec : '0;
            pending_priority_level_r <= found ? win_lvl : '0;
        end
    end

    // ------------------------------------------------------------
    // read path: data captured in setup, zero-wait access phase
    // ------------------------------------------------------------
    logic [31:0] rd_word;
    logic rd_hit;

    always_comb begin
        rd_word = 32'h00000000;
        rd_hit = 1'b1;
        if (hit_ctrl) begin
            rd_word[CTRL_ALT_BIT] = alt_table_select_r;
            rd_word[CTRL_TOP_BIT] = cpu_priority_top_bit;
            rd_word[CTRL_IPL_LSB +: 3] = cpu_priority_level_r;
        end else if (hit_status) begin
            rd_word[VEC_W-1:0] = pending_vector_number_r;
            rd_word[STAT_LVL_LSB +: LVL_W] = pending_priority_level_r;
        end else if (hit_trap) begin
            rd_word[NUM_TRAP-1:0] = trap_flag_r;
        end else if (hit_flag) begin
            rd_word = flag_pad[flag_idx*32 +: 32];
        end else if (hit_enable) begin
            rd_word = enable_pad[en_idx*32 +: 32];
        end else if (hit_pri) begin
            rd_word = pri_flat[pri_idx*32 +: 32];
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            pready <= 1'b1;
            prdata <= apb_req.pwrite ? 32'h00000000 : rd_word;
            pslverr <= ~rd_hit;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end
endmodule : ivp_controller

// [bench/ivp_controller_sva.sv]
// concurrent checks on the ports of the interrupt prioritizer
`timescale 1ns/1ps
module ivp_controller_sva (
    input wire logic clk,
    input wire logic rst,
    input wire ivp_pkg::ivp_apb_req_t apb_req,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic [ivp_pkg::NUM_IRQ-1:0] irq_in,
    input wire logic [ivp_pkg::NUM_TRAP-1:0] trap_in,
    input wire logic cpu_priority_top_bit,
    input wire ivp_pkg::ivp_core_req_t core_req
);
    import ivp_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic setup;
    assign setup = apb_req.psel && !apb_req.penable;
    AST_READY: assert property (setup |=> pready ##1 !pready)
        else $error("pready not one cycle after setup");
    AST_ERR: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_BAD_ADDR: assert property (setup && apb_req.paddr[1:0] != 2'h0 |=> pslverr && prdata == 32'h0)
        else $error("unaligned access not refused");
    AST_SLOT: assert property (core_req.req |->
        core_req.vec_addr == PRIMARY_TABLE_BASE + 24'(2 * core_req.vec_num) ||
        core_req.vec_addr == ALT_TABLE_BASE + 24'(2 * core_req.vec_num))
        else $error("slot address does not match vector");
    AST_RANGE: assert property (core_req.req |-> core_req.vec_num < 7'd126)
        else $error("vector number out of table");
    AST_TRAP_LVL: assert property (core_req.req && core_req.vec_num < 7'd8 |-> core_req.level == TRAP_LEVEL)
        else $error("trap vector with wrong level");
    AST_USER_LVL: assert property (core_req.req && core_req.vec_num >= 7'd8 |->
        core_req.level inside {[4'h1:4'h7]} && !cpu_priority_top_bit)
        else $error("user request not above cpu level");
    AST_TRAP0: assert property (trap_in[0] && !cpu_priority_top_bit |-> ##2 core_req.req && core_req.vec_num == 7'd0)
        else $error("vector 0 did not win");
    AST_RESET: assert property ($fell(rst) |-> !core_req.req && core_req.vec_addr == 24'h0)
        else $error("outputs not cleared by reset");
endmodule : ivp_controller_sva
bind ivp_controller ivp_controller_sva u_sva (.clk(clk), .rst(rst), .apb_req(apb_req), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .irq_in(irq_in), .trap_in(trap_in),
    .cpu_priority_top_bit(cpu_priority_top_bit), .core_req(core_req));

// [bench/ivp_core_model.sv]
// behavioural core: takes the request and fetches from the offered slot
`timescale 1ns/1ps
module ivp_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire ivp_pkg::ivp_core_req_t core_req,
    input wire logic mask_in,
    output logic cpu_priority_top_bit,
    output logic [23:0] fetch_addr
);
    import ivp_pkg::*;
    // top level bit is the core's own; software has no path to it
    assign cpu_priority_top_bit = mask_in;
    always_ff @(posedge clk) begin
        if (rst) begin
            fetch_addr <= RESET_FETCH_ADDR;
        end else if (core_req.req) begin
            fetch_addr <= core_req.vec_addr;
        end
    end
endmodule : ivp_core_model

// [bench/ivp_controller_bench.sv]
// self-checking bench for the vectored interrupt prioritizer
`timescale 1ns/1ps
`define CHK(e, a, nm) begin checks++; if ((a) !== (e)) begin fail_count++; \
    $display("wrong value %s exp %h got %h", nm, (e), (a)); end end
module ivp_controller_bench;
    import ivp_pkg::*;
    typedef struct packed {
        logic [6:0] n;
        logic [2:0] p;
        logic [2:0] c;
        logic a;
        logic q;
    } ivp_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    ivp_apb_req_t apb = '0;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [NUM_IRQ-1:0] irq = '0;
    logic [NUM_TRAP-1:0] trap = '0;
    logic mask = 1'b0;
    logic top;
    ivp_core_req_t creq;
    logic [23:0] fetch;
    int fail_count = 0;
    int checks = 0;
    logic [31:0] rd;
    logic er;
    logic [6:0] v;
    logic [11:0] fo;
    logic [11:0] po;
    // irq, priority, cpu level, alt table, request expected
    ivp_row_t rows [6] = '{'{7'd0, 3'd3, 3'd0, 1'b0, 1'b1}, '{7'd0, 3'd3, 3'd0, 1'b1, 1'b1},
        '{7'd117, 3'd7, 3'd6, 1'b0, 1'b1}, '{7'd46, 3'd2, 3'd2, 1'b0, 1'b0},
        '{7'd63, 3'd1, 3'd0, 1'b1, 1'b1}, '{7'd5, 3'd0, 3'd0, 1'b0, 1'b0}};
    always #10 clk = ~clk;
    ivp_controller u_dut (.clk(clk), .rst(rst), .apb_req(apb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .irq_in(irq), .trap_in(trap), .cpu_priority_top_bit(top), .core_req(creq));
    ivp_core_model u_core (.clk(clk), .rst(rst), .core_req(creq), .mask_in(mask),
        .cpu_priority_top_bit(top), .fetch_addr(fetch));
    task complete_run;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    // ------------------------------------------------------------
    // apb master and source stimulus
    // ------------------------------------------------------------
    task bus(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        int i;
        @(posedge clk);
        apb <= '{1'b1, 1'b0, w, ad, wd};
        @(posedge clk);
        apb.penable <= 1'b1;
        for (i = 0; i < 8; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 8) begin
            fail_count++;
            complete_run();
        end else begin
            rd = prdata;
            er = pslverr;
            apb <= '0;
        end
    endtask : bus
    task pulse(input logic [NUM_IRQ-1:0] m, input logic [NUM_TRAP-1:0] t);
        @(posedge clk);
        irq <= m;
        trap <= t;
        @(posedge clk);
        irq <= '0;
        trap <= '0;
        repeat (2) @(posedge clk);
        #1;
    endtask : pulse
    initial begin
        #1000000;
        fail_count++;
        complete_run();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHK(1'b0, creq.req, "req")
        `CHK(RESET_FETCH_ADDR, fetch, "fetch")
        bus(1'b0, OFS_CTRL, 32'h0);
        `CHK(32'h0, rd, "ctrl")
        $display("test reset done");
        foreach (rows[k]) begin
            v = rows[k].n + 7'd8;
            fo = OFS_FLAG + {8'h0, rows[k].n[6:5], 2'b00};
            po = OFS_PRIORITY + {6'h0, rows[k].n[6:3], 2'b00};
            bus(1'b1, OFS_CTRL, {16'h0, rows[k].a, 7'h0, rows[k].c, 5'h0});
            bus(1'b1, po, 32'(rows[k].p) << {rows[k].n[2:0], 2'b00});
            bus(1'b1, fo + 12'h010, 32'h1 << rows[k].n[4:0]);
            pulse(NUM_IRQ'(1) << rows[k].n, 8'h0);
            `CHK(rows[k].q, creq.req, "req")
            if (rows[k].q) begin
                `CHK(v, creq.vec_num, "vec")
                `CHK((rows[k].a ? ALT_TABLE_BASE : PRIMARY_TABLE_BASE) + 24'(2 * v), creq.vec_addr, "addr")
                `CHK({1'b0, rows[k].p}, creq.level, "lvl")
            end
            bus(1'b0, OFS_STATUS, 32'h0);
            `CHK(rows[k].p != 3'd0 ? {20'h0, 1'b0, rows[k].p, 1'b0, v} : 32'h0, rd, "status")
            bus(1'b1, fo, 32'h0);
            bus(1'b1, fo + 12'h010, 32'h0);
            bus(1'b1, po, 32'h0);
            $display("test row %0d done", k);
        end
        // ------------------------------------------------------------
        // awkward cases
        // ------------------------------------------------------------
        bus(1'b1, OFS_CTRL, 32'h0);
        bus(1'b1, OFS_PRIORITY, 32'h5440);
        bus(1'b1, OFS_ENABLE, 32'he);
        pulse(NUM_IRQ'(6), 8'h0);
        `CHK(7'd9, creq.vec_num, "tie")
        pulse(NUM_IRQ'(8), 8'h0);
        `CHK(7'd11, creq.vec_num, "level")
        bus(1'b0, OFS_FLAG, 32'h0);
        `CHK(32'he, rd, "sticky")
        bus(1'b1, OFS_ENABLE, 32'h0);
        repeat (2) @(posedge clk);
        #1;
        `CHK(1'b0, creq.req, "gated")
        bus(1'b1, OFS_FLAG, 32'h0);
        bus(1'b1, OFS_PRIORITY, 32'h7);
        bus(1'b1, OFS_ENABLE, 32'h1);
        pulse(NUM_IRQ'(1), 8'h04);
        `CHK(7'd2, creq.vec_num, "trap")
        `CHK(TRAP_LEVEL, creq.level, "trap lvl")
        `CHK(PRIMARY_TABLE_BASE + 24'h4, fetch, "fetch")
        pulse('0, 8'h01);
        `CHK(7'd0, creq.vec_num, "vec0")
        bus(1'b1, OFS_CTRL, 32'h100);
        bus(1'b0, OFS_CTRL, 32'h0);
        `CHK(32'h0, rd, "top ro")
        @(posedge clk);
        mask <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        `CHK(1'b0, creq.req, "masked")
        bus(1'b0, OFS_CTRL, 32'h0);
        `CHK(32'h100, rd, "top mirror")
        bus(1'b1, OFS_TRAP, 32'hff);
        bus(1'b0, OFS_TRAP, 32'h0);
        `CHK(32'h0, rd, "trap clr")
        mask <= 1'b0;
        bus(1'b0, 12'h0fe, 32'h0);
        `CHK(1'b1, er, "err")
        `CHK(32'h0, rd, "err data")
        pulse(NUM_IRQ'(1), 8'h0);
        `CHK(1'b1, creq.req, "pend")
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, OFS_FLAG, 32'h0);
        `CHK(32'h0, rd, "flag rst")
        `CHK(1'b0, creq.req, "req rst")
        $display("test awkward done");
        complete_run();
    end
endmodule : ivp_controller_bench
